// ==== pesm_top.sv ====
// presence eeprom serial master: apb registers and the four-bus bit engine
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
module pesm_top #(
	parameter int unsigned TIMEOUT_CYC = pesm_pkg::TIMEOUT_CYC,
	parameter int unsigned QTR_CYC     = pesm_pkg::QTR_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic [3:0]  scl_in,
	output logic      [3:0]  scl_out,
	output logic      [3:0]  scl_oe_n,
	input  wire logic [3:0]  sda_in,
	output logic      [3:0]  sda_out,
	output logic      [3:0]  sda_oe_n
);
	localparam int unsigned NB = pesm_pkg::NUM_BUS;

	logic [NB-1:0]          scl_s;
	logic [NB-1:0]          sda_s;
	pesm_pkg::pesm_cmd_t    cmd_q;
	pesm_pkg::pesm_stat_t   stat_q;
	pesm_pkg::pesm_state_t  st_q;
	logic [pesm_pkg::EV_W-1:0] ist_q;
	logic [pesm_pkg::EV_W-1:0] imask_q;
	logic [pesm_pkg::EV_W-1:0] ev;
	logic [15:0]            qcnt_q;
	logic [1:0]             ph_q;
	logic [2:0]             bit_q;
	logic [1:0]             idx_q;
	logic [7:0]             sh_q;
	logic                   rs_q;
	logic                   err_q;
	logic                   scl_low_q;
	logic                   sda_low_q;
	logic [31:0]            tmo_q;
	logic                   bus_scl;
	logic                   bus_sda;
	logic                   tick;
	logic                   stretch;
	logic                   adv;
	logic                   end_ph;
	logic                   acc;
	logic                   wr_en;
	logic                   launch;
	logic                   rx_byte;
	logic                   tmo_hit;
	logic                   fin;
	pesm_pkg::pesm_cmd_t    wcmd;

	pesm_sync #(
		.W (2 * NB)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({scl_in, sda_in}),
		.sync_out ({scl_s, sda_s})
	);

	assign bus_scl = scl_s[cmd_q.bus];
	assign bus_sda = sda_s[cmd_q.bus];
	assign wcmd    = pesm_pkg::pesm_cmd_t'(pwdata);

	// apb: first access cycle registers the answer, second completes it
	assign acc   = psel && penable && pready;
	assign wr_en = acc && pwrite;
	// launch only with a valid op while idle; command writes during busy are dropped
	assign launch = wr_en && (paddr == pesm_pkg::ADDR_CMD) && !stat_q.busy
		&& ((wcmd.op == pesm_pkg::OP_READ) || (wcmd.op == pesm_pkg::OP_WRITE));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready) begin
				case (paddr)
					pesm_pkg::ADDR_CMD:   prdata <= cmd_q;
					pesm_pkg::ADDR_STAT:  prdata <= stat_q;
					pesm_pkg::ADDR_ISTAT: prdata <= {29'h0000_0000, ist_q};
					pesm_pkg::ADDR_IMASK: prdata <= {29'h0000_0000, imask_q};
					default:              pslverr <= 1'b1;
				endcase
			end
		end
	end

	// command register holds address, bus, offset and data of the last launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= pesm_pkg::CMD_RESET;
		end else if (launch) begin
			cmd_q <= wcmd;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imask_q <= pesm_pkg::EV_RESET;
		end else if (wr_en && paddr == pesm_pkg::ADDR_IMASK) begin
			imask_q <= pwdata[pesm_pkg::EV_W-1:0];
		end
	end

	// sticky events; an event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_q <= pesm_pkg::EV_RESET;
		end else begin
			if (wr_en && paddr == pesm_pkg::ADDR_ISTAT) begin
				ist_q <= (ist_q & ~pwdata[pesm_pkg::EV_W-1:0]) | ev;
			end else begin
				ist_q <= ist_q | ev;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ist_q & imask_q);
		end
	end

	// quarter-bit divider: 4 quarters per 10 us bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qcnt_q <= 16'h0000;
		end else if (st_q == pesm_pkg::ST_IDLE || stretch
			|| qcnt_q == 16'(QTR_CYC - 1)) begin
			qcnt_q <= 16'h0000;
		end else begin
			qcnt_q <= qcnt_q + 16'h0001;
		end
	end

	assign tick = (qcnt_q == 16'(QTR_CYC - 1));
	// a target holding scl low after release stretches the bit
	assign stretch = !scl_low_q && !bus_scl && (st_q == pesm_pkg::ST_BIT
		|| st_q == pesm_pkg::ST_ACK) && ph_q[1];
	assign adv    = tick && !stretch;
	assign end_ph = adv && (ph_q == 2'h3);
	assign rx_byte = (idx_q == 2'h3);
	assign tmo_hit = (st_q == pesm_pkg::ST_ACK) && (tmo_q >= TIMEOUT_CYC - 1);
	assign fin     = (st_q == pesm_pkg::ST_STOP) && end_ph;

	// time-out runs from the end of the last bit until the ack is seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_q <= 32'h0000_0000;
		end else if (st_q == pesm_pkg::ST_ACK && !rx_byte) begin
			tmo_q <= tmo_q + 32'h0000_0001;
		end else begin
			tmo_q <= 32'h0000_0000;
		end
	end

	// sequencer: start, address, offset, [restart, address] data, ack, stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q  <= pesm_pkg::ST_IDLE;
			ph_q  <= 2'h0;
			bit_q <= 3'h0;
			idx_q <= 2'h0;
			sh_q  <= 8'h00;
			rs_q  <= 1'b0;
			err_q <= 1'b0;
		end else begin
			if (adv) begin
				ph_q <= ph_q + 2'h1;
			end
			case (st_q)
				pesm_pkg::ST_IDLE: begin
					ph_q <= 2'h0;
					if (launch) begin
						st_q  <= pesm_pkg::ST_START;
						idx_q <= 2'h0;
						rs_q  <= 1'b0;
						err_q <= 1'b0;
						sh_q  <= {wcmd.slave, 1'b0};
					end
				end
				pesm_pkg::ST_START: begin
					if (end_ph) begin
						st_q  <= pesm_pkg::ST_BIT;
						bit_q <= 3'h0;
					end
				end
				pesm_pkg::ST_BIT: begin
					if (end_ph) begin
						sh_q  <= {sh_q[6:0], bus_sda};
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							st_q <= pesm_pkg::ST_ACK;
						end
					end
				end
				pesm_pkg::ST_ACK: begin
					if (tmo_hit) begin
						st_q  <= pesm_pkg::ST_STOP;
						ph_q  <= 2'h0;
						err_q <= 1'b1;
					end else if (end_ph) begin
						if (!rx_byte && bus_sda) begin
							st_q  <= pesm_pkg::ST_STOP;
							err_q <= 1'b1;
						end else if (rx_byte
							|| (idx_q == 2'h2 && cmd_q.op == pesm_pkg::OP_WRITE)) begin
							st_q <= pesm_pkg::ST_STOP;
						end else if (idx_q == 2'h1 && cmd_q.op == pesm_pkg::OP_READ) begin
							st_q  <= pesm_pkg::ST_START;
							rs_q  <= 1'b1;
							idx_q <= 2'h2;
							sh_q  <= {cmd_q.slave, 1'b1};
						end else begin
							st_q  <= pesm_pkg::ST_BIT;
							bit_q <= 3'h0;
							idx_q <= idx_q + 2'h1;
							if (idx_q == 2'h0) begin
								sh_q <= cmd_q.offset;
							end else if (cmd_q.op == pesm_pkg::OP_WRITE) begin
								sh_q <= cmd_q.data;
							end else begin
								sh_q <= 8'hFF;
							end
						end
					end
				end
				pesm_pkg::ST_STOP: begin
					if (end_ph) begin
						st_q <= pesm_pkg::ST_IDLE;
					end
				end
				default: begin
					st_q <= pesm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// line drive per phase; low means pull the open-drain line down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else begin
			case (st_q)
				pesm_pkg::ST_START: begin
					scl_low_q <= rs_q && (ph_q == 2'h0);
					sda_low_q <= ph_q[1];
				end
				pesm_pkg::ST_BIT: begin
					scl_low_q <= !ph_q[1];
					sda_low_q <= !rx_byte && !sh_q[7];
				end
				pesm_pkg::ST_ACK: begin
					scl_low_q <= !ph_q[1];
					sda_low_q <= 1'b0; // master nacks the read byte by releasing
				end
				pesm_pkg::ST_STOP: begin
					scl_low_q <= (ph_q == 2'h0);
					sda_low_q <= (ph_q != 2'h3);
				end
				default: begin
					scl_low_q <= 1'b0;
					sda_low_q <= 1'b0;
				end
			endcase
		end
	end

	// only the selected bus is ever driven; the others stay released
	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_bus
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					scl_oe_n[gi] <= 1'b1;
					sda_oe_n[gi] <= 1'b1;
					scl_out[gi]  <= 1'b0;
					sda_out[gi]  <= 1'b0;
				end else begin
					scl_oe_n[gi] <= !(scl_low_q && cmd_q.bus == 2'(gi));
					sda_oe_n[gi] <= !(sda_low_q && cmd_q.bus == 2'(gi));
					scl_out[gi]  <= 1'b0;
					sda_out[gi]  <= 1'b0;
				end
			end
		end
	endgenerate

	assign ev[pesm_pkg::EV_READ]  = fin && !err_q && cmd_q.op == pesm_pkg::OP_READ;
	assign ev[pesm_pkg::EV_WRITE] = fin && !err_q && cmd_q.op == pesm_pkg::OP_WRITE;
	assign ev[pesm_pkg::EV_ERROR] = fin && err_q;

	// status: completion flags cleared on launch, set as busy drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 32'h0000_0000;
		end else begin
			if (launch) begin
				stat_q.busy       <= 1'b1;
				stat_q.read_done  <= 1'b0;
				stat_q.write_done <= 1'b0;
				stat_q.bus_error  <= 1'b0;
			end else if (fin) begin
				stat_q.busy       <= 1'b0;
				stat_q.read_done  <= ev[pesm_pkg::EV_READ];
				stat_q.write_done <= ev[pesm_pkg::EV_WRITE];
				stat_q.bus_error  <= ev[pesm_pkg::EV_ERROR];
				if (ev[pesm_pkg::EV_READ]) begin
					stat_q.data <= sh_q;
				end
			end
		end
	end
endmodule : pesm_top

// ==== pesm_pkg.sv ====
// package: constants, layouts and types of the presence eeprom serial master
// Operation
// - The block masters four separate 100 kHz presence buses, one per memory branch and channel.
// - Each bus carries up to four eeproms, each picked by its own slave address.
// - A command is finished once read-done, write-done or bus-error reads 1; only then may the next go.
// - Launching a read or write clears the read-done, write-done and bus-error flags at once.
// - Busy reads 1 for the whole time the interface is executing a command.
// - A read runs a random byte read, puts the byte in status bits 7:0 and then sets read-done.
// - A write sends the command's data byte with a byte write and then sets write-done.
// - A missing acknowledge at any acknowledge point ends the command and sets bus-error.
// - A time-out starts after the last bit is sent while awaiting a response; expiry sets bus-error.
package pesm_pkg;

	localparam int unsigned CLK_HZ      = 250_000_000;
	localparam int unsigned SCL_HZ      = 100_000;
	localparam int unsigned QTR_CYC     = CLK_HZ / (SCL_HZ * 4);
	localparam int unsigned TIMEOUT_US  = 1000;
	localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1_000_000) * TIMEOUT_US;
	localparam int unsigned NUM_BUS     = 4;

	localparam logic [7:0] ADDR_CMD   = 8'h00;
	localparam logic [7:0] ADDR_STAT  = 8'h04;
	localparam logic [7:0] ADDR_ISTAT = 8'h08;
	localparam logic [7:0] ADDR_IMASK = 8'h0C;

	localparam logic [1:0] OP_READ  = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;

	localparam int unsigned EV_READ  = 0;
	localparam int unsigned EV_WRITE = 1;
	localparam int unsigned EV_ERROR = 2;
	localparam int unsigned EV_W     = 3;

	localparam logic [31:0] CMD_RESET  = 32'h0000_0000;
	localparam logic [EV_W-1:0] EV_RESET = 3'h0;

	typedef struct packed {
		logic [1:0] rsv1;
		logic [1:0] op;
		logic [1:0] rsv0;
		logic [1:0] bus;
		logic       rsvb;
		logic [6:0] slave;
		logic [7:0] offset;
		logic [7:0] data;
	} pesm_cmd_t;

	typedef struct packed {
		logic [19:0] rsv;
		logic        busy;
		logic        bus_error;
		logic        write_done;
		logic        read_done;
		logic [7:0]  data;
	} pesm_stat_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_BIT,
		ST_ACK,
		ST_STOP
	} pesm_state_t;

endpackage : pesm_pkg

// ==== pesm_sync.sv ====
// two-flop synchroniser for the bus pin inputs
`timescale 1ns/100ps
module pesm_sync #(
	parameter int unsigned W = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// pins idle high on an open-drain bus, so reset to released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '1;
			sync_out <= '1;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pesm_sync

// ==== pesm_checker.sv ====
// assertion checker for the presence eeprom serial master
`timescale 1ns/100ps
module pesm_checker #(
	parameter int QTR = pesm_pkg::QTR_CYC
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic [3:0]  scl_out,
	input wire logic [3:0]  scl_oe_n,
	input wire logic [3:0]  sda_out,
	input wire logic [3:0]  sda_oe_n
);
	// two quarters to the start condition plus pipeline slack
	localparam int MAXW = 2 * QTR + 50;
	logic [11:0] lo_q;
	int          wt_q;
	logic        launch;
	// only a launch seen with every line released is timed; one while any line is driven is ignored
	assign launch = pready && psel && penable && pwrite && paddr == 8'h00 && ^pwdata[29:28]
		&& &scl_oe_n && &sda_oe_n;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_q <= 12'h000;
			wt_q <= 0;
		end else begin
			lo_q <= &scl_oe_n ? 12'h000 : lo_q + 12'h001;
			wt_q <= launch ? 1 : (wt_q != 0 && &sda_oe_n) ? wt_q + 1 : 0;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	a_pready_wait: assert property (s_access |=> s_done)
		else $error("pready not one cycle after access");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_pready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata outside completion");
	a_slverr_map: assert property (pready |-> pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
		else $error("pslverr wrong for address");
	a_lines_low: assert property (scl_out == 4'h0 && sda_out == 4'h0)
		else $error("open drain output not low");
	a_one_bus: assert property ($onehot0(~(scl_oe_n & sda_oe_n)))
		else $error("more than one bus driven");
	a_scl_low: assert property ($rose(&scl_oe_n)
		|-> lo_q == 12'(QTR) || lo_q == 12'(2 * QTR))
		else $error("clock low time not a quarter multiple");
	a_start_soon: assert property (wt_q <= MAXW)
		else $error("no start after launch");
	c_launch: cover property (launch);
endmodule : pesm_checker
bind pesm_top pesm_checker #(.QTR(QTR_CYC)) pesm_checker_i (.pclk(pclk),
	.presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n));

// ==== pesm_eeprom.sv ====
// behavioural presence eeprom on one two-wire bus
`timescale 1ns/100ps
module pesm_eeprom #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic nack,
	output logic      sda_oe_n
);
	logic [7:0] mem [256];
	logic [7:0] sh, ptr;
	logic       sel, rd, rd_n;
	int         bc, nb;
	initial sda_oe_n = 1'b1;
	// start or restart; stop needs no action
	always @(negedge sda) if (scl) begin
		bc = 0;
		nb = 0;
		rd = 1'b0;
		sel = 1'b0;
	end
	always @(posedge scl) begin
		sh = {sh[6:0], sda};
		bc++;
	end
	always @(negedge scl) begin
		sda_oe_n = 1'b1;
		if (bc == 8 && !rd) begin
			if (nb == 0) begin
				sel = sh[7:1] == ADDR && !nack;
				rd_n = sh[0];
			end else if (sel && nb == 1)
				ptr = sh;
			else if (sel)
				mem[ptr] = sh;
			sda_oe_n = !sel;
		end else if (bc == 9) begin
			bc = 0;
			nb++;
			rd = rd_n;
		end
		// only the first byte after a read address is ours to drive
		if (rd && sel && nb == 1 && bc < 8)
			sda_oe_n = mem[ptr][7 - bc];
	end
endmodule : pesm_eeprom

// ==== presence_eeprom_smbus_master_test.sv ====
// self-checking bench for the presence eeprom serial master
`timescale 1ns/100ps
module presence_eeprom_smbus_master_test;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0001_150A;
	logic        pready, pslverr, irq;
	logic [3:0]  scl_oe_n, sda_oe_n;
	wire  [3:0]  sda_ln;
	wire  [15:0] ee_n;
	logic [15:0] nk = 16'h0000;
	logic [3:0]  hold = 4'h0;
	logic [2:0]  msk;
	logic [7:0]  ref_mem [int];
	int          fail_count = 0, tests_run = 0;
	// an 80 ns bit keeps the run short; hold stretches the clock line as a target would
	pesm_top #(.TIMEOUT_CYC(3000), .QTR_CYC(5)) pesm_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.scl_in(scl_oe_n & ~hold), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_ln),
		.sda_out(), .sda_oe_n(sda_oe_n));
	for (genvar g = 0; g < 16; g++) begin : ee
		pesm_eeprom #(.ADDR(7'h50 | 7'(g % 4))) pesm_eeprom_i (.scl(scl_oe_n[g / 4]),
			.sda(sda_ln[g / 4]), .nack(nk[g]), .sda_oe_n(ee_n[g]));
	end
	// wired-and with pull-up: released lines read high
	assign sda_ln = sda_oe_n & {&ee_n[15:12], &ee_n[11:8], &ee_n[7:4], &ee_n[3:0]};
	initial forever #2 pclk = ~pclk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic err = 1'b0);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no limit here: only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		chk("pready wait", 32'h2, 32'(n));
		chk("pslverr", {31'h0, err}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic run(input string nm, input logic [1:0] op, b, s, input logic [7:0] o, d,
		input logic [2:0] ef);
		logic [31:0] c;
		int          k, n;
		c = {2'h0, op, 2'h0, b, 1'b0, 5'h14, s, o, d};
		k = {b, s, o};
		n = 0;
		apb(1'b1, pesm_pkg::ADDR_CMD, c);
		apb(1'b0, pesm_pkg::ADDR_STAT, 32'h0);
		chk("flags at launch", 32'h8, 32'(rd[11:8]));
		apb(1'b1, pesm_pkg::ADDR_CMD, c ^ 32'h3000_00FF);
		apb(1'b0, pesm_pkg::ADDR_CMD, 32'h0);
		chk("command while busy", c, rd);
		do begin
			apb(1'b0, pesm_pkg::ADDR_STAT, 32'h0);
			n++;
		end while (rd[10:8] === 3'h0 && n < 2000);
		chk("flags at end", 32'(ef), 32'(rd[11:8]));
		if (op == pesm_pkg::OP_READ && ef == 3'h1)
			chk("read data", 32'(ref_mem[k]), 32'(rd[7:0]));
		if (op == pesm_pkg::OP_WRITE && ef == 3'h2)
			ref_mem[k] = d;
		apb(1'b0, pesm_pkg::ADDR_ISTAT, 32'h0);
		chk("event status", 32'(ef), rd);
		chk("irq", 32'(|(ef & msk)), {31'h0, irq});
		apb(1'b1, pesm_pkg::ADDR_ISTAT, 32'h7);
		// irq trails the status register by one cycle
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test %s done", nm);
	endtask : run
	initial begin
		#200_000;
		fail_count++;
		$display("FAIL watchdog expected finish seen hang");
		test_done();
	end
	initial begin
		logic [1:0] b, s;
		logic [7:0] o, d;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 20; a += 4) begin
			apb(1'b0, 8'(a), 32'h0, a == 16);
			chk("reset value", 32'h0, a < 16 ? rd : 32'h0);
		end
		apb(1'b1, 8'h10, 32'h1, 1'b1);
		msk = 3'h7;
		apb(1'b1, pesm_pkg::ADDR_IMASK, 32'h7);
		apb(1'b0, pesm_pkg::ADDR_IMASK, 32'h0);
		chk("mask", 32'h7, rd);
		for (int p = 0; p < 4; p += 3) begin
			apb(1'b1, pesm_pkg::ADDR_CMD, {2'h0, 2'(p), 28'h05A_00A5});
			apb(1'b0, pesm_pkg::ADDR_STAT, 32'h0);
			chk("bad op ignored", 32'h0, rd);
		end
		$display("test registers done");
		b = 2'(xs());
		s = 2'(xs());
		o = 8'(xs());
		d = 8'(xs());
		run("write", pesm_pkg::OP_WRITE, b, s, o, d, 3'h2);
		run("read", pesm_pkg::OP_READ, b, s, o, 8'h00, 3'h1);
		msk = 3'h0;
		apb(1'b1, pesm_pkg::ADDR_IMASK, 32'h0);
		nk[{b, s}] <= 1'b1;
		run("nack", pesm_pkg::OP_READ, b, s, o, 8'h00, 3'h4);
		nk[{b, s}] <= 1'b0;
		// the ninth clock high is the address ack: keep it low until the time-out fires
		fork
			run("timeout", pesm_pkg::OP_WRITE, b, s, o, d, 3'h4);
			begin
				repeat (9) @(posedge scl_oe_n[b]);
				hold[b] <= 1'b1;
			end
		join
		hold <= 4'h0;
		test_done();
	end
endmodule : presence_eeprom_smbus_master_test
